// >>> core/rbp_config_regs.sv
// receive buffer width-mode and partition-count registers, both cores
// assumes an apb master on ref_clk and consumers that sample the decoded
// bank settings and partition selects on the same clock
//
// What this block does
// - bank 0 width mode from bits 0:1
// - bank 1 width mode from bits 2:3
// - banks 2,3 width mode from bits 4:5, 6:7
// - partition and per-core register copies at indices
// - partition count: 2-bit field per bank, same positions
// - width code 00 gives 32-bit bank
// - width code 01 gives 64-bit bank
// - width code 10 gives 128-bit bank
// - partition code gives 1, 2, 4, 8 fifos
// - 3-bit read address selects fifo; ignored if one
`timescale 1ns/1ps

module rbp_config_regs
  import rbp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb slave
  input wire rbp_apb_req_s apbReq,
  output rbp_apb_rsp_s apbRsp,
  // fifo read address per core and bank
  input wire logic [RBP_NUM_CORE-1:0][RBP_NUM_BANK-1:0][RBP_SEL_W-1:0]
    fifoRdAddr,
  // decoded settings per core and bank
  output rbp_bank_cfg_s [RBP_NUM_CORE-1:0][RBP_NUM_BANK-1:0] bankCfg,
  output logic [RBP_NUM_CORE-1:0][RBP_NUM_BANK-1:0][RBP_SEL_W-1:0] fifoSel
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [RBP_NUM_CORE-1:0][RBP_REG_W-1:0] pcnt_ff, nxt_pcnt;
  logic [RBP_NUM_CORE-1:0][RBP_REG_W-1:0] wmode_ff, nxt_wmode;
  rbp_apb_rsp_s rsp_ff, nxt_rsp;
  logic [RBP_NUM_CORE-1:0] rsvSeen, pairBad;

  logic [RBP_IDX_W-1:0] idx;
  logic aligned;
  logic access;

  assign idx = apbReq.paddr[RBP_ADDR_W-1:2];
  assign aligned = (apbReq.paddr[1:0] == RBP_BYTE_LSB);
  // answer on the second access cycle so that every answer is registered
  assign access = apbReq.psel & apbReq.penable & ~rsp_ff.pready;

  // ---------------------------------------------------------------
  // pairing and reserved checks, shown in the status words
  // ---------------------------------------------------------------
  // fields are compared as width and count together; a mismatch only
  // flags, the device still runs each bank from its own fields
  always_comb begin
    for (int c = 0; c < RBP_NUM_CORE; c++) begin
      logic [RBP_NUM_BANK-1:0][3:0] f;
      logic any64lo, any64hi, any128, rsv;
      f = '0;
      any64lo = 1'b0;
      any64hi = 1'b0;
      any128 = 1'b0;
      rsv = 1'b0;
      for (int b = 0; b < RBP_NUM_BANK; b++) begin
        f[b] = {wmode_ff[c][b*RBP_FLD_W +: RBP_FLD_W],
                pcnt_ff[c][b*RBP_FLD_W +: RBP_FLD_W]};
        if (wmode_ff[c][b*RBP_FLD_W +: RBP_FLD_W] == RBP_W128) begin
          any128 = 1'b1;
        end
        if (wmode_ff[c][b*RBP_FLD_W +: RBP_FLD_W] == RBP_WRSV) begin
          rsv = 1'b1;
        end
        if (wmode_ff[c][b*RBP_FLD_W +: RBP_FLD_W] == RBP_W64) begin
          if (b < 2) begin
            any64lo = 1'b1;
          end else begin
            any64hi = 1'b1;
          end
        end
      end
      rsvSeen[c] = rsv;
      pairBad[c] = (any64lo & (f[0] != f[1]))
                 | (any64hi & (f[2] != f[3]))
                 | (any128 & ((f[0] != f[1]) | (f[0] != f[2])
                              | (f[0] != f[3])));
    end
  end

  // ---------------------------------------------------------------
  // apb register access
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pcnt = pcnt_ff;
    nxt_wmode = wmode_ff;
    nxt_rsp = '0;
    if (access) begin
      nxt_rsp.pready = 1'b1;
      if (!aligned) begin
        nxt_rsp.pslverr = 1'b1;
      end else begin
        case (idx)
          RBP_IDX_PCNT_A: begin
            if (apbReq.pwrite) begin
              nxt_pcnt[0] = apbReq.pwdata[RBP_REG_W-1:0];
            end
            nxt_rsp.prdata[RBP_REG_W-1:0] = pcnt_ff[0];
          end
          RBP_IDX_WMODE_A: begin
            if (apbReq.pwrite) begin
              nxt_wmode[0] = apbReq.pwdata[RBP_REG_W-1:0];
            end
            nxt_rsp.prdata[RBP_REG_W-1:0] = wmode_ff[0];
          end
          RBP_IDX_PCNT_B: begin
            if (apbReq.pwrite) begin
              nxt_pcnt[1] = apbReq.pwdata[RBP_REG_W-1:0];
            end
            nxt_rsp.prdata[RBP_REG_W-1:0] = pcnt_ff[1];
          end
          RBP_IDX_WMODE_B: begin
            if (apbReq.pwrite) begin
              nxt_wmode[1] = apbReq.pwdata[RBP_REG_W-1:0];
            end
            nxt_rsp.prdata[RBP_REG_W-1:0] = wmode_ff[1];
          end
          // status words are read only; writes are dropped silently
          RBP_IDX_STAT_A: begin
            nxt_rsp.prdata[RBP_STAT_RSV_BIT] = rsvSeen[0];
            nxt_rsp.prdata[RBP_STAT_PAIR_BIT] = pairBad[0];
          end
          RBP_IDX_STAT_B: begin
            nxt_rsp.prdata[RBP_STAT_RSV_BIT] = rsvSeen[1];
            nxt_rsp.prdata[RBP_STAT_PAIR_BIT] = pairBad[1];
          end
          default: begin
            nxt_rsp.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pcnt_ff <= {RBP_NUM_CORE{RBP_PCNT_RST}};
      wmode_ff <= {RBP_NUM_CORE{RBP_WMODE_RST}};
      rsp_ff <= '0;
    end else begin
      pcnt_ff <= nxt_pcnt;
      wmode_ff <= nxt_wmode;
      rsp_ff <= nxt_rsp;
    end
  end

  assign apbRsp = rsp_ff;

  // ---------------------------------------------------------------
  // per bank decode and partition select
  // ---------------------------------------------------------------
  // settings reach the consumers one cycle after the register write
  for (genvar c = 0; c < RBP_NUM_CORE; c++) begin : g_core
    for (genvar b = 0; b < RBP_NUM_BANK; b++) begin : g_bank
      rbp_bank_cfg_s cfg_ff, nxt_cfg;
      logic [RBP_SEL_W-1:0] sel_ff, nxt_sel;
      logic [RBP_FLD_W-1:0] wFld, pFld;

      assign wFld = wmode_ff[c][b*RBP_FLD_W +: RBP_FLD_W];
      assign pFld = pcnt_ff[c][b*RBP_FLD_W +: RBP_FLD_W];

      always_comb begin
        nxt_cfg = '0;
        nxt_cfg.width = rbp_width_e'(wFld);
        case (wFld)
          RBP_W32: nxt_cfg.is32 = 1'b1;
          RBP_W64: nxt_cfg.is64 = 1'b1;
          RBP_W128: nxt_cfg.is128 = 1'b1;
          default: nxt_cfg.reserved = 1'b1;
        endcase
        // same decode in every width mode
        case (pFld)
          RBP_PART1: begin
            nxt_cfg.numFifo = RBP_NUM1;
            nxt_cfg.addrMask = RBP_MASK1;
          end
          RBP_PART2: begin
            nxt_cfg.numFifo = RBP_NUM2;
            nxt_cfg.addrMask = RBP_MASK2;
          end
          RBP_PART4: begin
            nxt_cfg.numFifo = RBP_NUM4;
            nxt_cfg.addrMask = RBP_MASK4;
          end
          default: begin
            nxt_cfg.numFifo = RBP_NUM8;
            nxt_cfg.addrMask = RBP_MASK8;
          end
        endcase
        // address bits beyond the partition count are ignored, so with
        // one partition every address lands on fifo 0
        nxt_sel = fifoRdAddr[c][b] & nxt_cfg.addrMask;
      end

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          cfg_ff <= '0;
          sel_ff <= '0;
        end else begin
          cfg_ff <= nxt_cfg;
          sel_ff <= nxt_sel;
        end
      end

      assign bankCfg[c][b] = cfg_ff;
      assign fifoSel[c][b] = sel_ff;
    end
  end

endmodule

// >>> core/rbp_pkg.sv
// shared constants and types of the receive buffer partition configuration
// assumes a single 40 MHz clock and an apb register bus of 32-bit words
package rbp_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int RBP_NUM_CORE = 2;
  localparam int RBP_NUM_BANK = 4;
  localparam int RBP_FLD_W = 2;
  localparam int RBP_REG_W = 8;
  localparam int RBP_IDX_W = 18;
  localparam int RBP_ADDR_W = 20;
  localparam int RBP_DATA_W = 32;
  localparam int RBP_SEL_W = 3;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_PCNT_A = 18'h30906;
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_WMODE_A = 18'h30907;
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_STAT_A = 18'h30908;
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_PCNT_B = 18'h30a06;
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_WMODE_B = 18'h30a07;
  localparam logic [RBP_IDX_W-1:0] RBP_IDX_STAT_B = 18'h30a08;
  localparam logic [1:0] RBP_BYTE_LSB = 2'h0;

  // ---------------------------------------------------------------
  // reset values and status bits
  // ---------------------------------------------------------------
  localparam logic [RBP_REG_W-1:0] RBP_PCNT_RST = 8'h00;
  localparam logic [RBP_REG_W-1:0] RBP_WMODE_RST = 8'h00;
  localparam int RBP_STAT_RSV_BIT = 0;
  localparam int RBP_STAT_PAIR_BIT = 1;

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  typedef enum logic [RBP_FLD_W-1:0] {
    RBP_W32 = 2'h0,
    RBP_W64 = 2'h1,
    RBP_W128 = 2'h2,
    RBP_WRSV = 2'h3
  } rbp_width_e;

  localparam logic [RBP_FLD_W-1:0] RBP_PART1 = 2'h0;
  localparam logic [RBP_FLD_W-1:0] RBP_PART2 = 2'h1;
  localparam logic [RBP_FLD_W-1:0] RBP_PART4 = 2'h2;
  localparam logic [RBP_FLD_W-1:0] RBP_PART8 = 2'h3;
  localparam logic [3:0] RBP_NUM1 = 4'h1;
  localparam logic [3:0] RBP_NUM2 = 4'h2;
  localparam logic [3:0] RBP_NUM4 = 4'h4;
  localparam logic [3:0] RBP_NUM8 = 4'h8;
  localparam logic [RBP_SEL_W-1:0] RBP_MASK1 = 3'h0;
  localparam logic [RBP_SEL_W-1:0] RBP_MASK2 = 3'h1;
  localparam logic [RBP_SEL_W-1:0] RBP_MASK4 = 3'h3;
  localparam logic [RBP_SEL_W-1:0] RBP_MASK8 = 3'h7;

  // decoded setting of one bank, handed to buffer, mapper and read side
  typedef struct packed {
    rbp_width_e width;
    logic is32;
    logic is64;
    logic is128;
    logic reserved;
    logic [3:0] numFifo;
    logic [RBP_SEL_W-1:0] addrMask;
  } rbp_bank_cfg_s;

  // apb request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [RBP_ADDR_W-1:0] paddr;
    logic [RBP_DATA_W-1:0] pwdata;
  } rbp_apb_req_s;

  typedef struct packed {
    logic [RBP_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } rbp_apb_rsp_s;

endpackage

// >>> verif/rbp_config_asserts.sv
// assertions on the partition configuration register ports
// bound into every rbp_config_regs instance, one clock domain
`timescale 1ns/1ps
module rbp_config_asserts
  import rbp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // apb and bank side
  input wire rbp_apb_req_s apbReq,
  input wire rbp_apb_rsp_s apbRsp,
  input wire logic [1:0][3:0][2:0] fifoRdAddr,
  input wire rbp_bank_cfg_s [1:0][3:0] bankCfg,
  input wire logic [1:0][3:0][2:0] fifoSel
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // decode is only valid from the second edge after reset release
  for (genvar c = 0; c < 2; c++) begin : g_core
    for (genvar b = 0; b < 4; b++) begin : g_bank
      rbp_bank_cfg_s k;
      assign k = bankCfg[c][b];
      a_w32_decode: assert property (
        $past(rstn) && k.width == RBP_W32 |-> k.is32 && !k.is64)
        else $error("bad 32-bit decode");
      a_w64_decode: assert property (
        $past(rstn) && k.width == RBP_W64 |-> k.is64 && !k.is128)
        else $error("bad 64-bit decode");
      a_w128_decode: assert property (
        $past(rstn) && k.width == RBP_W128 |-> k.is128 && !k.is32)
        else $error("bad 128-bit decode");
      a_rsv_decode: assert property (
        $past(rstn) && k.width == RBP_WRSV |-> k.reserved && !k.is32)
        else $error("bad reserved decode");
      a_count_mask: assert property (
        $past(rstn) |-> {1'b0, k.addrMask} + 4'h1 == k.numFifo)
        else $error("fifo count and mask disagree");
      a_sel_mask: assert property (
        $past(rstn) |-> fifoSel[c][b] ==
        ($past(fifoRdAddr[c][b]) & k.addrMask))
        else $error("fifo select not masked read address");
    end
  end

  a_ready_time: assert property (
    apbReq.psel && !apbReq.penable |-> ##1 !apbRsp.pready ##1 apbRsp.pready)
    else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (
    apbRsp.pready |=> !apbRsp.pready) else $error("ready too long");
  a_rdata_byte: assert property (
    apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");

  c_err: cover property (apbRsp.pslverr);
  c_w128: cover property (bankCfg[0][0].width == RBP_W128);
  c_part8: cover property (bankCfg[1][3].numFifo == RBP_NUM8);
endmodule

bind rbp_config_regs rbp_config_asserts chk (.ref_clk(ref_clk),
  .rstn(rstn), .apbReq(apbReq), .apbRsp(apbRsp),
  .fifoRdAddr(fifoRdAddr), .bankCfg(bankCfg), .fifoSel(fifoSel));

// >>> verif/test_rbp_config_regs.sv
// self-checking bench of the partition configuration registers
// the bench is the apb master and drives the fifo read addresses
`timescale 1ns/1ps
module test_rbp_config_regs
  import rbp_pkg::*;
;
  logic ref_clk;
  logic rstn;
  rbp_apb_req_s apbReq;
  rbp_apb_rsp_s apbRsp;
  logic [1:0][3:0][2:0] fifoRdAddr;
  logic [1:0][3:0][2:0] fifoSel;
  rbp_bank_cfg_s [1:0][3:0] bankCfg;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] wa;
  logic [7:0] wb;
  logic [7:0] pb;
  int errCount;
  int checksDone;
  // core b settings per pass, bank 3 in the top bits; every pass keeps
  // 64-bit pairs and 128-bit groups identical in width and count
  localparam logic [3:0][7:0] WB_SET = {8'h55, 8'haa, 8'h05, 8'h50};
  localparam logic [3:0][7:0] PB_SET = {8'h0f, 8'h55, 8'hca, 8'hf9};

  rbp_config_regs uut (.ref_clk(ref_clk), .rstn(rstn), .apbReq(apbReq),
    .apbRsp(apbRsp), .fifoRdAddr(fifoRdAddr), .bankCfg(bankCfg),
    .fifoSel(fifoSel));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task endOfTest();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input logic [39:0] seen, input logic [39:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // upper write bits are set on purpose: only the low byte may land
  task apb(input logic wr, input logic [17:0] idx, input logic [1:0] lsb,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, wr, {idx, lsb}, {24'hffffff, d}};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq <= '0;
    if (apbRsp.pready !== 1'b1) begin
      errCount++;
      endOfTest();
    end
  endtask

  task rd(input logic [17:0] idx, input logic [7:0] d);
    apb(1'b0, idx, RBP_BYTE_LSB, 8'h00);
    chk({rerr, rdat}, {1'b0, 24'h0, d});
  endtask

  task cbank(input int c, input int b, input logic [1:0] w,
    input logic [1:0] p);
    rbp_bank_cfg_s k;
    k = bankCfg[c][b];
    chk({k.width, k.is32, k.is64, k.is128, k.reserved, k.numFifo,
      k.addrMask}, {w, 4'h8 >> w, 4'h1 << p, 3'h7 >> (3 - p)});
    chk(fifoSel[c][b], fifoRdAddr[c][b] & (3'h7 >> (3 - p)));
  endtask

  initial begin
    rstn = 1'b0;
    apbReq = '0;
    fifoRdAddr = '0;
    errCount = 0;
    checksDone = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
      cbank(i / 4, i % 4, 2'h0, 2'h0);
    rd(RBP_IDX_PCNT_A, 8'h00);
    rd(RBP_IDX_WMODE_B, 8'h00);
    // core b walks the legal mode mixes; core a sets all banks alike and
    // the last pass writes the reserved width code on purpose
    for (int w = 0; w < 4; w++) begin
      wa = {4{2'(w)}};
      wb = WB_SET[w];
      pb = PB_SET[w];
      @(posedge ref_clk);
      fifoRdAddr <= {8{3'(w + 5)}} ^ 24'h53ac61;
      apb(1'b1, RBP_IDX_WMODE_A, RBP_BYTE_LSB, wa);
      apb(1'b1, RBP_IDX_PCNT_A, RBP_BYTE_LSB, wa);
      apb(1'b1, RBP_IDX_WMODE_B, RBP_BYTE_LSB, wb);
      apb(1'b1, RBP_IDX_PCNT_B, RBP_BYTE_LSB, pb);
      rd(RBP_IDX_WMODE_A, wa);
      rd(RBP_IDX_PCNT_B, pb);
      rd(RBP_IDX_STAT_A, {7'h0, w == 3});
      rd(RBP_IDX_STAT_B, 8'h00);
      repeat (2) @(negedge ref_clk);
      for (int b = 0; b < 4; b++) begin
        cbank(0, b, 2'(w), 2'(w));
        cbank(1, b, wb[2*b +: 2], pb[2*b +: 2]);
      end
    end
    apb(1'b1, RBP_IDX_WMODE_A, 2'h2, 8'h00);
    chk(rerr, 1'b1);
    apb(1'b1, 18'h30905, RBP_BYTE_LSB, 8'h00);
    chk(rerr, 1'b1);
    rd(RBP_IDX_WMODE_A, 8'hff);
    rd(RBP_IDX_PCNT_A, 8'hff);
    endOfTest();
  end
endmodule
